// file: pkg/asr_defines.svh
// timing counts and field widths for the static ram host controller
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH
`define ASR_ADDR_W 10
`define ASR_DATA_W 4
`define ASR_DEPTH 1024
`define ASR_CLK_PERIOD_NS 25
// slowest grade figures in ns
`define ASR_ACCESS_NS 450
`define ASR_WRITE_NS 200
`define ASR_WRITE_RELEASE_NS 0
`define ASR_OUT_RELEASE_NS 100
`define ASR_DESELECT_NS 100
// least times round up; the release time is held to at least one cycle
`define ASR_ACCESS_CYC ((`ASR_ACCESS_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_WRITE_CYC ((`ASR_WRITE_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_REL_RAW ((`ASR_WRITE_RELEASE_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_RELEASE_CYC ((`ASR_REL_RAW < 1) ? 1 : `ASR_REL_RAW)
`define ASR_TURN_CYC ((`ASR_OUT_RELEASE_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_DESEL_CYC ((`ASR_DESELECT_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_CNT_W 6
`endif

// file: pkg/asr_pkg.sv
// types for the static ram host controller
`include "asr_defines.svh"
package asr_pkg;
    typedef struct packed {
        logic write;
        logic [`ASR_ADDR_W-1:0] addr;
        logic [`ASR_DATA_W-1:0] wdata;
    } asr_req_t;
    typedef struct packed {
        logic [`ASR_ADDR_W-1:0] word_addr;
        logic select_n;
        logic write_n;
        logic [`ASR_DATA_W-1:0] data_out;
        logic data_oe;
    } asr_pins_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_TURN = 6'h02,
        ST_READ = 6'h04,
        ST_WRITE = 6'h08,
        ST_REL = 6'h10,
        ST_GAP = 6'h20
    } asr_state_t;
endpackage

// file: hw/asr_sync.sv
// two flop synchroniser for the data pins read back from the memory
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_sync
    import asr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [`ASR_DATA_W-1:0] d,
    output logic [`ASR_DATA_W-1:0] q
);
    logic [`ASR_DATA_W-1:0] meta_q;
    logic [`ASR_DATA_W-1:0] meta_d;
    logic [`ASR_DATA_W-1:0] q_d;

    always_comb begin
        meta_d = d;
        q_d = meta_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule

// file: hw/asr_host.sv
// host side controller driving a 1024 x 4 asynchronous static ram
`timescale 1ns/1ps
`include "asr_defines.svh"
// Operation
// - The host keeps the address steady through the write and the release time after it.
// - The host holds the write strobe, select and write data for the minimum write time.
// - The host holds write data until the write strobe has risen.
// - The host spaces cycles no closer than the cycle time, equal to the access time.
module asr_host
    import asr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire asr_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [`ASR_DATA_W-1:0] rsp_data,
    output logic [`ASR_ADDR_W-1:0] word_addr,
    output logic select_n,
    output logic write_n,
    output logic [`ASR_DATA_W-1:0] shared_data_pins_out,
    output logic shared_data_pins_oe,
    input wire logic [`ASR_DATA_W-1:0] shared_data_pins_in
);
    localparam logic [`ASR_CNT_W-1:0] ACCESS_CYC = `ASR_CNT_W'(`ASR_ACCESS_CYC);
    localparam logic [`ASR_CNT_W-1:0] WRITE_CYC = `ASR_CNT_W'(`ASR_WRITE_CYC);
    localparam logic [`ASR_CNT_W-1:0] RELEASE_CYC = `ASR_CNT_W'(`ASR_RELEASE_CYC);
    localparam logic [`ASR_CNT_W-1:0] TURN_CYC = `ASR_CNT_W'(`ASR_TURN_CYC);
    localparam logic [`ASR_CNT_W-1:0] DESEL_CYC = `ASR_CNT_W'(`ASR_DESEL_CYC);
    // synchroniser adds two cycles; sample that much after the access time
    localparam logic [`ASR_CNT_W-1:0] SYNC_CYC = 6'h02;

    asr_state_t state_q, state_d;
    logic [`ASR_CNT_W-1:0] cnt_q, cnt_d;
    asr_pins_t pins_q, pins_d;
    logic req_ready_q, req_ready_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [`ASR_DATA_W-1:0] rsp_data_q, rsp_data_d;
    logic [`ASR_DATA_W-1:0] rd_sync;
    // cycle length of the last access, for spacing the next one
    logic [`ASR_CNT_W-1:0] used_q, used_d;

    asr_sync u_sync (
        .clk(clk),
        .rst(rst),
        .d(shared_data_pins_in),
        .q(rd_sync)
    );

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pins_d = pins_q;
        req_ready_d = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        used_d = used_q;
        case (state_q)
            ST_IDLE: begin
                req_ready_d = 1'b1;
                if (req_valid && req_ready_q) begin
                    req_ready_d = 1'b0;
                    // address set up with the write strobe high, no write possible yet; a read drops select here
                    pins_d.word_addr = req.addr;
                    pins_d.data_out = req.wdata;
                    cnt_d = '0;
                    used_d = '0;
                    if (req.write) begin
                        // wait out any lingering read drive before we drive
                        pins_d.data_oe = 1'b0;
                        state_d = ST_TURN;
                    end else begin
                        pins_d.select_n = 1'b0;
                        pins_d.write_n = 1'b1;
                        pins_d.data_oe = 1'b0;
                        state_d = ST_READ;
                    end
                end
            end
            ST_TURN: begin
                cnt_d = cnt_q + 6'h01;
                used_d = used_q + 6'h01;
                if (cnt_q + 6'h01 >= DESEL_CYC) begin
                    pins_d.select_n = 1'b0;
                    pins_d.write_n = 1'b0;
                    cnt_d = '0;
                    state_d = ST_WRITE;
                end
            end
            ST_WRITE: begin
                cnt_d = cnt_q + 6'h01;
                used_d = used_q + 6'h01;
                // drive only after the memory has let go of the pins
                if (cnt_q + 6'h01 >= TURN_CYC) begin
                    pins_d.data_oe = 1'b1;
                end
                if (cnt_q + 6'h01 >= TURN_CYC + WRITE_CYC) begin
                    pins_d.write_n = 1'b1;
                    pins_d.select_n = 1'b1;
                    cnt_d = '0;
                    state_d = ST_REL;
                end
            end
            ST_REL: begin
                // address and data held past the strobe edge
                cnt_d = cnt_q + 6'h01;
                used_d = used_q + 6'h01;
                if (cnt_q + 6'h01 >= RELEASE_CYC) begin
                    pins_d.data_oe = 1'b0;
                    cnt_d = '0;
                    state_d = ST_GAP;
                end
            end
            ST_READ: begin
                cnt_d = cnt_q + 6'h01;
                used_d = used_q + 6'h01;
                if (cnt_q + 6'h01 >= ACCESS_CYC + SYNC_CYC) begin
                    rsp_data_d = rd_sync;
                    rsp_valid_d = 1'b1;
                    pins_d.select_n = 1'b1;
                    cnt_d = '0;
                    state_d = ST_GAP;
                end
            end
            ST_GAP: begin
                // pad to the cycle time and let the memory float its pins
                cnt_d = cnt_q + 6'h01;
                used_d = used_q + 6'h01;
                if ((used_q + 6'h01 >= ACCESS_CYC) && (cnt_q + 6'h01 >= DESEL_CYC)) begin
                    req_ready_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                pins_d.select_n = 1'b1;
                pins_d.write_n = 1'b1;
                pins_d.data_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            used_q <= '0;
            pins_q.word_addr <= '0;
            pins_q.select_n <= 1'b1;
            pins_q.write_n <= 1'b1;
            pins_q.data_out <= '0;
            pins_q.data_oe <= 1'b0;
            req_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            used_q <= used_d;
            pins_q <= pins_d;
            req_ready_q <= req_ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
        end
    end

    always_comb begin
        req_ready = req_ready_q;
        rsp_valid = rsp_valid_q;
        rsp_data = rsp_data_q;
        word_addr = pins_q.word_addr;
        select_n = pins_q.select_n;
        write_n = pins_q.write_n;
        shared_data_pins_out = pins_q.data_out;
        shared_data_pins_oe = pins_q.data_oe;
    end
endmodule

// file: tb/asr_sram_model.sv
// behavioural 1024 x 4 static ram on the far side of the host
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_sram_model
    import asr_pkg::*;
(
    input wire logic [`ASR_ADDR_W-1:0] word_addr,
    input wire logic select_n,
    input wire logic write_n,
    input wire logic [`ASR_DATA_W-1:0] host_data,
    input wire logic host_oe,
    output logic [`ASR_DATA_W-1:0] pin_level
);
    logic [`ASR_DATA_W-1:0] mem [`ASR_DEPTH];
    logic [`ASR_DATA_W-1:0] rd_q = 4'h0;
    logic [`ASR_DATA_W-1:0] float_q = 4'h5;
    logic drive = 1'b0;
    int acc_ns = 100;
    // old word stays on the pins this long; keep below acc_ns
    int hold_ns = 50;
    // released pins show the inverse so a stale sample cannot pass
    assign pin_level = host_oe ? host_data : (drive ? rd_q : float_q);
    always @(negedge drive) float_q = ~rd_q;
    always @(negedge host_oe) float_q = ~host_data;
    always @* if (!select_n && !write_n) mem[word_addr] = pin_level;
    always @(word_addr, select_n, write_n) begin
        drive <= #(hold_ns) 1'b0;
        rd_q <= #(acc_ns) mem[word_addr];
        drive <= #(acc_ns) !select_n && write_n;
    end
endmodule

// file: tb/asr_host_sva.sv
// pin timing assertions for the static ram host controller
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_host_sva
    import asr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic rsp_valid,
    input wire logic [`ASR_ADDR_W-1:0] word_addr,
    input wire logic select_n,
    input wire logic write_n,
    input wire logic [`ASR_DATA_W-1:0] shared_data_pins_out,
    input wire logic shared_data_pins_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    addr_hold_a: assert property (!write_n |=> $stable(word_addr))
        else $error("address moved in write");
    strobe_width_a: assert property ($fell(write_n) |-> !write_n [*8])
        else $error("write strobe too short");
    data_overlap_a: assert property ($rose(shared_data_pins_oe) |->
        (shared_data_pins_oe && !write_n && !select_n) [*8]) else $error("data overlap short");
    data_hold_a: assert property (!write_n && shared_data_pins_oe |=>
        shared_data_pins_oe && $stable(shared_data_pins_out)) else $error("data not held");
    cycle_space_a: assert property ($fell(select_n) |=>
        !$fell(select_n) [*8] ##1 !$fell(select_n) [*8] ##1 !$fell(select_n))
        else $error("cycles too close");
    read_answer_a: assert property ($fell(select_n) && write_n |-> ##20 rsp_valid)
        else $error("read answer late");
endmodule
bind asr_host asr_host_sva u_asr_host_sva (.clk, .rst, .rsp_valid, .word_addr, .select_n,
    .write_n, .shared_data_pins_out, .shared_data_pins_oe);

// file: tb/tb_asr_host.sv
// self-checking bench for the static ram host controller
`timescale 1ns/1ps
`include "asr_defines.svh"
module tb_asr_host
    import asr_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    asr_req_t req = '0;
    logic req_ready, rsp_valid, select_n, write_n, oe;
    logic [`ASR_DATA_W-1:0] rsp_data, dout, pins;
    logic [`ASR_ADDR_W-1:0] word_addr;
    int mismatches = 0;
    int checks_done = 0;
    always #12.5 clk = ~clk;
    asr_host u_asr_host (.clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data,
        .word_addr, .select_n, .write_n, .shared_data_pins_out(dout),
        .shared_data_pins_oe(oe), .shared_data_pins_in(pins));
    asr_sram_model u_asr_sram_model (.word_addr, .select_n, .write_n, .host_data(dout),
        .host_oe(oe), .pin_level(pins));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // lat is the read answer distance from the taken edge
    task automatic op(input logic wr, input logic [9:0] a, input logic [3:0] d, input int lat);
        int k;
        @(posedge clk);
        req <= '{wr, a, d};
        req_valid <= 1'b1;
        k = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        check(req_ready, 1'b1, "request never taken");
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        check(req_ready, 1'b0, "taken while busy");
        if (!wr) begin
            check({word_addr, select_n, write_n, oe}, {a, 3'b010}, "read pins");
            k = 1;
            while (rsp_valid !== 1'b1 && k < 200) begin
                @(negedge clk);
                k++;
            end
            check(k, lat, "read latency");
            check(rsp_data, d, "read data");
        end else begin
            // turn wait of 4 plus output release of 4 before driving
            k = 0;
            while (oe !== 1'b1 && k < 40) begin
                @(negedge clk);
                k++;
            end
            check(k, 8, "data drive delay");
            check({word_addr, dout, select_n, write_n}, {a, d, 2'b00}, "write pins");
        end
    endtask
    task automatic t_reset;
        @(negedge clk);
        check({select_n, write_n, oe, req_ready}, 4'hC, "pins in reset");
        $display("reset test done");
    endtask
    task automatic t_fill;
        logic [9:0] a [4] = '{10'h000, 10'h3FF, 10'h2AA, 10'h155};
        for (int i = 0; i < 4; i++) op(1'b1, a[i], a[i][3:0] ^ 4'h9, 0);
        for (int i = 0; i < 4; i++) op(1'b0, a[i], a[i][3:0] ^ 4'h9, 21);
        $display("fill test done");
    endtask
    // slow answers near the access limit, overwrite then back to back reads
    task automatic t_slow;
        u_asr_sram_model.acc_ns = 420;
        op(1'b1, 10'h2AA, 4'h5, 0);
        op(1'b0, 10'h2AA, 4'h5, 21);
        op(1'b0, 10'h155, 4'hC, 21);
        $display("slow test done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        t_reset();
        @(posedge clk);
        rst <= 1'b0;
        t_fill();
        t_slow();
        final_report();
    end
    initial begin
        #50us;
        mismatches++;
        final_report();
    end
endmodule
